/* File: src/acs_pkg.sv */
// package: register map, field layout and timing constants of the conversion sequencer
`default_nettype none
package acs_pkg;
    // register index (plain port address)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_RESULT = 4'h1;
    localparam logic [3:0] ADDR_INJ_RESULT = 4'h2;
    localparam logic [3:0] ADDR_TIMING = 4'h3;
    localparam logic [3:0] ADDR_SCAN_MASK = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
    localparam logic [3:0] ADDR_INJ_CTRL = 4'h7;
    // control register fields
    localparam int CTRL_CH_LSB = 0;
    localparam int CTRL_CH_W = 4;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_START = 6;
    localparam int CTRL_WAIT_READ = 7;
    localparam int CTRL_GROUP = 8;
    localparam int CTRL_OVR_SUSPEND = 9;
    localparam int CTRL_BUSY = 15;
    // injection control fields
    localparam int INJ_CH_LSB = 0;
    localparam int INJ_GROUP = 4;
    localparam int INJ_REQ = 5;
    // timing register fields
    localparam int TIM_SAMPLE_LSB = 0;
    localparam int TIM_CONV_LSB = 8;
    localparam int TIM_W = 8;
    // interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_INJ_DONE = 2;
    localparam int IRQ_W = 3;
    // widths
    localparam int RES_W = 10;
    localparam int CH_W = 5;
    localparam int DATA_W = 16;
    localparam int GRP0_CH = 16;
    localparam int GRP1_CH = 8;
    localparam int NUM_CH = 24;
    // reset values
    localparam logic [15:0] TIMING_RESET = 16'h0404;
    localparam logic [15:0] SCAN_MASK_RESET = 16'hffff;
    // calibration time in cpu clock cycles
    localparam int CAL_CYCLES = 40630;
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_CONT = 2'b01,
        MODE_SCAN = 2'b10,
        MODE_SCAN_CONT = 2'b11
    } acs_mode_t;
endpackage
`default_nettype wire

/* File: src/acs_calib.sv */
// post-reset calibration timer holding the busy flag
`default_nettype none
module acs_calib #(
    parameter int CAL_CYCLES = acs_pkg::CAL_CYCLES
) (
    input wire logic MCLK_I,
    input wire logic RESET_I,
    output logic busy_o
);
    logic [15:0] count;

    // count down from reset, busy until zero
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            count <= 16'(CAL_CYCLES - 1);
            busy_o <= 1'b1;
        end
        else if (count != 16'h0000)
        begin
            count <= count - 16'h0001;
        end
        else
        begin
            busy_o <= 1'b0;
        end
    end

    chk_busy_len: assert property (@(posedge MCLK_I) $fell(RESET_I) |-> busy_o [*8])
        else $error("busy flag dropped early");
endmodule
`default_nettype wire

/* File: src/acs_conv_core.sv */
// sample and conversion timer with analog result capture
`default_nettype none
module acs_conv_core (
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic start_i,
    input wire logic [7:0] sample_len_i,
    input wire logic [7:0] conv_len_i,
    input wire logic [9:0] analog_i,
    output logic busy_o,
    output logic done_o,
    output logic [9:0] result_o
);
    logic [8:0] count;
    logic converting;

    // sample phase then conversion phase, each of programmed length plus one
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            busy_o <= 1'b0;
            converting <= 1'b0;
            count <= 9'h000;
            done_o <= 1'b0;
            result_o <= 10'h000;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i && !busy_o)
            begin
                busy_o <= 1'b1;
                converting <= 1'b0;
                count <= {1'b0, sample_len_i};
            end
            else if (busy_o && count != 9'h000)
            begin
                count <= count - 9'h001;
            end
            else if (busy_o && !converting)
            begin
                converting <= 1'b1;
                result_o <= analog_i; // held at end of sampling
                count <= {1'b0, conv_len_i};
            end
            else if (busy_o)
            begin
                busy_o <= 1'b0;
                done_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: src/acs_top.sv */
// conversion sequencer top: registers, mode control, overrun, injection, interrupts
//
// The address map and the strobed register port were chosen for this implementation.
`default_nettype none
// Function
// - one of 24 inputs is converted at a time giving a 10-bit result.
// - a control bit chooses the 16-input group or the 8-input group.
// - a self-calibration runs after every reset.
// - sample and conversion durations are software programmable.
// - overrun either raises an interrupt or suspends the next conversion until read.
// - single mode converts the selected channel once into the result register.
// - continuous mode repeatedly converts the selected channel.
// - scan single mode converts each selected channel once with an event per result.
// - scan continuous mode cycles the selected channels repeatedly.
// - in continuous modes wait-for-read holds a new result in a buffer and stalls until the result is read.
// - an injected conversion during continuous mode writes the injected result register.
// - after injection the continuous mode resumes unchanged.
// - calibration lasts at most 40630 cycles with the busy flag set throughout.
// - unused analog pins remain readable as digital inputs.
module acs_top #(
    parameter int CAL_CYCLES = acs_pkg::CAL_CYCLES
) (
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [15:0] RDATA_O,
    input wire logic [159:0] GRP0_LEVEL_I,
    input wire logic [79:0] GRP1_LEVEL_I,
    input wire logic [15:0] GRP0_DIGITAL_I,
    input wire logic [7:0] GRP1_DIGITAL_I,
    output logic [15:0] GRP0_DIGITAL_O,
    output logic [7:0] GRP1_DIGITAL_O,
    output logic IRQ_O
);
    logic [3:0] ctrl_ch;
    logic [1:0] ctrl_mode;
    logic start;
    logic wait_read;
    logic group_sel;
    logic ovr_suspend;
    logic [15:0] timing;
    logic [15:0] scan_mask;
    logic [3:0] inj_ch;
    logic inj_group;
    logic inj_pending;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [9:0] result;
    logic [3:0] result_ch;
    logic result_unread;
    logic [9:0] inj_result;
    logic [9:0] hold_buf;
    logic [3:0] hold_ch;
    logic hold_full;
    logic cal_busy;
    logic core_busy;
    logic core_done;
    logic [9:0] core_result;
    logic core_start;
    logic [3:0] cur_ch;
    logic cur_inj;
    logic [3:0] conv_ch;
    logic conv_group;
    logic [9:0] analog_level;
    logic wr_ctrl;
    logic rd_result;
    logic rd_status;
    logic continuous;
    logic scanning;
    logic seq_last;
    logic [3:0] next_scan_ch;
    logic [9:0] grp0_lvl [16];
    logic [9:0] grp1_lvl [8];
    logic [2:0] next_irq_status;
    logic hold_stall;
    logic ovr_stall;
    logic [3:0] resume_ch;

    acs_calib #(
        .CAL_CYCLES(CAL_CYCLES)
    ) u_calib (
        .MCLK_I(MCLK_I),
        .RESET_I(RESET_I),
        .busy_o(cal_busy)
    );

    acs_conv_core u_core (
        .MCLK_I(MCLK_I),
        .RESET_I(RESET_I),
        .start_i(core_start),
        .sample_len_i(timing[acs_pkg::TIM_SAMPLE_LSB +: acs_pkg::TIM_W]),
        .conv_len_i(timing[acs_pkg::TIM_CONV_LSB +: acs_pkg::TIM_W]),
        .analog_i(analog_level),
        .busy_o(core_busy),
        .done_o(core_done),
        .result_o(core_result)
    );

    // unpack the analog level buses per channel
    genvar gi;
    generate
        for (gi = 0; gi < acs_pkg::GRP0_CH; gi++)
        begin : g_grp0
            assign grp0_lvl[gi] = GRP0_LEVEL_I[gi*acs_pkg::RES_W +: acs_pkg::RES_W];
            if (gi < acs_pkg::GRP1_CH)
            begin : g_grp1
                assign grp1_lvl[gi] = GRP1_LEVEL_I[gi*acs_pkg::RES_W +: acs_pkg::RES_W];
            end
        end
    endgenerate

    // analog multiplexer, group chosen by control or injection
    assign conv_group = cur_inj ? inj_group : group_sel;
    assign analog_level = conv_group ? grp1_lvl[conv_ch[2:0]] : grp0_lvl[conv_ch];

    // digital pins always readable
    assign GRP0_DIGITAL_O = GRP0_DIGITAL_I;
    assign GRP1_DIGITAL_O = GRP1_DIGITAL_I;

    // decode and mode helpers
    assign wr_ctrl = WR_I && ADDR_I == acs_pkg::ADDR_CTRL;
    assign rd_result = RD_I && ADDR_I == acs_pkg::ADDR_RESULT;
    assign rd_status = RD_I && ADDR_I == acs_pkg::ADDR_IRQ_STATUS;
    assign continuous = ctrl_mode == acs_pkg::MODE_CONT || ctrl_mode == acs_pkg::MODE_SCAN_CONT;
    assign scanning = ctrl_mode[1];
    assign seq_last = !scanning || cur_ch == 4'h0;

    // next channel in scan: next lower channel, wrapping to the configured top
    always_comb
    begin
        next_scan_ch = (cur_ch == 4'h0) ? ctrl_ch : cur_ch - 4'h1;
        if (!scanning)
        begin
            next_scan_ch = ctrl_ch;
        end
    end

    // stall conditions for starting the next conversion
    assign hold_stall = hold_full;
    assign ovr_stall = ovr_suspend && result_unread;
    assign core_start = start && !cal_busy && !core_busy && !core_done && !hold_stall && !ovr_stall;
    assign conv_ch = cur_ch;

    // control register: mode, channel, start bit
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            ctrl_ch <= 4'h0;
            ctrl_mode <= acs_pkg::MODE_SINGLE;
            start <= 1'b0;
            wait_read <= 1'b0;
            group_sel <= 1'b0;
            ovr_suspend <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            ctrl_ch <= WDATA_I[acs_pkg::CTRL_CH_LSB +: acs_pkg::CTRL_CH_W];
            ctrl_mode <= WDATA_I[acs_pkg::CTRL_MODE_LSB +: 2];
            start <= WDATA_I[acs_pkg::CTRL_START];
            wait_read <= WDATA_I[acs_pkg::CTRL_WAIT_READ];
            group_sel <= WDATA_I[acs_pkg::CTRL_GROUP];
            ovr_suspend <= WDATA_I[acs_pkg::CTRL_OVR_SUSPEND];
        end
        else if (core_done && !cur_inj && !continuous && seq_last)
        begin
            start <= 1'b0;
        end
    end

    // timing, scan mask, interrupt mask and injection control registers
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            timing <= acs_pkg::TIMING_RESET;
            scan_mask <= acs_pkg::SCAN_MASK_RESET;
            irq_mask <= 3'h0;
            inj_ch <= 4'h0;
            inj_group <= 1'b0;
        end
        else if (WR_I)
        begin
            if (ADDR_I == acs_pkg::ADDR_TIMING)
            begin
                timing <= WDATA_I;
            end
            if (ADDR_I == acs_pkg::ADDR_SCAN_MASK)
            begin
                scan_mask <= WDATA_I;
            end
            if (ADDR_I == acs_pkg::ADDR_IRQ_MASK)
            begin
                irq_mask <= WDATA_I[acs_pkg::IRQ_W-1:0];
            end
            if (ADDR_I == acs_pkg::ADDR_INJ_CTRL)
            begin
                inj_ch <= WDATA_I[acs_pkg::INJ_CH_LSB +: 4];
                inj_group <= WDATA_I[acs_pkg::INJ_GROUP];
            end
        end
    end

    // injection request: accepted only in continuous modes, dropped when served
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            inj_pending <= 1'b0;
        end
        else if (WR_I && ADDR_I == acs_pkg::ADDR_INJ_CTRL && WDATA_I[acs_pkg::INJ_REQ] && continuous)
        begin
            inj_pending <= 1'b1;
        end
        else if (core_start && cur_inj)
        begin
            inj_pending <= 1'b0;
        end
    end

    // channel sequencing; injection taken between conversions, scan position kept
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            cur_ch <= 4'h0;
            cur_inj <= 1'b0;
            resume_ch <= 4'h0;
        end
        else if (wr_ctrl)
        begin
            cur_ch <= WDATA_I[acs_pkg::CTRL_CH_LSB +: acs_pkg::CTRL_CH_W];
            cur_inj <= 1'b0;
        end
        else if (core_done)
        begin
            if (cur_inj)
            begin
                cur_inj <= 1'b0;
                cur_ch <= resume_ch; // scan position saved on entry
            end
            else if (inj_pending && continuous)
            begin
                cur_inj <= 1'b1;
                cur_ch <= inj_ch;
                resume_ch <= next_scan_ch;
            end
            else
            begin
                cur_ch <= next_scan_ch;
            end
        end
    end

    // result register, hold buffer and unread tracking
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            result <= 10'h000;
            result_ch <= 4'h0;
            result_unread <= 1'b0;
            hold_buf <= 10'h000;
            hold_ch <= 4'h0;
            hold_full <= 1'b0;
            inj_result <= 10'h000;
        end
        else
        begin
            if (rd_result && hold_full)
            begin
                result <= hold_buf;
                result_ch <= hold_ch;
                hold_full <= 1'b0;
                result_unread <= 1'b1;
            end
            else if (rd_result)
            begin
                result_unread <= 1'b0;
            end
            if (core_done && cur_inj)
            begin
                inj_result <= core_result;
            end
            else if (core_done && wait_read && continuous && result_unread && !rd_result)
            begin
                hold_buf <= core_result;
                hold_ch <= cur_ch;
                hold_full <= 1'b1;
            end
            else if (core_done)
            begin
                result <= core_result;
                result_ch <= cur_ch;
                result_unread <= 1'b1;
            end
        end
    end

    // sticky interrupt status: set wins over read-clear
    always_comb
    begin
        next_irq_status = rd_status ? 3'h0 : irq_status;
        if (core_done && !cur_inj)
        begin
            next_irq_status[acs_pkg::IRQ_DONE] = 1'b1;
        end
        if (core_done && !cur_inj && result_unread && !rd_result && !(wait_read && continuous))
        begin
            next_irq_status[acs_pkg::IRQ_OVERRUN] = 1'b1;
        end
        if (core_done && cur_inj)
        begin
            next_irq_status[acs_pkg::IRQ_INJ_DONE] = 1'b1;
        end
    end

    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            irq_status <= 3'h0;
        end
        else
        begin
            irq_status <= next_irq_status;
        end
    end

    assign IRQ_O = |(irq_status & irq_mask);

    // read data, valid the cycle after the read strobe
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            RDATA_O <= 16'h0000;
        end
        else if (RD_I)
        begin
            unique case (ADDR_I)
                acs_pkg::ADDR_CTRL: RDATA_O <= {cal_busy, core_busy, 4'h0, ovr_suspend, group_sel, wait_read,
                    start, ctrl_mode, ctrl_ch};
                acs_pkg::ADDR_RESULT: RDATA_O <= {result_ch, 2'b00, result};
                acs_pkg::ADDR_INJ_RESULT: RDATA_O <= {inj_group, inj_ch, 1'b0, inj_result};
                acs_pkg::ADDR_TIMING: RDATA_O <= timing;
                acs_pkg::ADDR_SCAN_MASK: RDATA_O <= scan_mask;
                acs_pkg::ADDR_IRQ_STATUS: RDATA_O <= {13'h0000, irq_status};
                acs_pkg::ADDR_IRQ_MASK: RDATA_O <= {13'h0000, irq_mask};
                acs_pkg::ADDR_INJ_CTRL: RDATA_O <= {10'h000, inj_pending, inj_group, inj_ch};
                default: RDATA_O <= 16'h0000;
            endcase
        end
        else
        begin
            RDATA_O <= 16'h0000;
        end
    end

    sequence s_done_unread;
        core_done && !cur_inj && result_unread && !rd_result;
    endsequence

    chk_no_start_cal: assert property (@(posedge MCLK_I) disable iff (RESET_I) cal_busy |-> !core_start)
        else $error("conversion started during calibration");
    chk_overrun_flag: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (s_done_unread and !(wait_read && continuous)) |=> irq_status[acs_pkg::IRQ_OVERRUN])
        else $error("overrun not flagged");
    chk_suspend_ovr: assert property (@(posedge MCLK_I) disable iff (RESET_I) ovr_stall |-> !core_start)
        else $error("conversion not suspended on overrun");
    chk_hold_stall: assert property (@(posedge MCLK_I) disable iff (RESET_I) hold_full |-> !core_start)
        else $error("conversion ran with held result");
    chk_single_stop: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        core_done && !cur_inj && !continuous && seq_last && !wr_ctrl |=> !start)
        else $error("start bit not cleared");
    chk_inj_result: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        core_done && cur_inj |=> inj_result == $past(core_result))
        else $error("injected result not stored");
    chk_mode_kept: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        core_done && cur_inj && !wr_ctrl |=> ctrl_mode == $past(ctrl_mode) && !cur_inj)
        else $error("mode changed by injection");
    chk_scan_down: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        core_done && !cur_inj && scanning && !inj_pending && !wr_ctrl && cur_ch != 4'h0
        |=> cur_ch == $past(cur_ch) - 4'h1)
        else $error("scan did not step down");
    chk_irq_level: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        IRQ_O |-> (irq_status & irq_mask) != 3'h0)
        else $error("interrupt without unmasked status");
endmodule
`default_nettype wire

/* File: tb/acs_src_model.sv */
// analog source and digital pin model driving the converter inputs
`default_nettype none
module acs_src_model (
    input wire logic [4:0] bump_i,
    output logic [159:0] grp0_level_o,
    output logic [79:0] grp1_level_o,
    output logic [15:0] grp0_digital_o,
    output logic [7:0] grp1_digital_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // each level encodes its group, its channel and a drift term
    always_comb
    begin
        for (int n = 0; n < 16; n++)
            grp0_level_o[10*n +: 10] = {1'b0, n[3:0], bump_i};
        for (int n = 0; n < 8; n++)
            grp1_level_o[10*n +: 10] = {1'b1, n[3:0], bump_i};
    end
    // digital pin levels follow the drift term
    assign grp0_digital_o = {11'h5a3, bump_i};
    assign grp1_digital_o = {3'h6, bump_i};
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// register level testbench of the conversion sequencer
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CAL = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [4:0] bump = 5'h05;
    logic [15:0] rdata;
    logic [15:0] rv;
    logic [159:0] lvl0;
    logic [79:0] lvl1;
    logic [15:0] din0;
    logic [15:0] dout0;
    logic [7:0] din1;
    logic [7:0] dout1;
    logic irq;
    int err_count = 0;
    int compares = 0;
    int n;
    int p [2];

    // 10 MHz clock
    initial forever #50 clk = ~clk;

    acs_src_model i_src (.bump_i(bump), .grp0_level_o(lvl0), .grp1_level_o(lvl1),
        .grp0_digital_o(din0), .grp1_digital_o(din1));

    acs_top #(.CAL_CYCLES(CAL)) i_dut (.MCLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .GRP0_LEVEL_I(lvl0), .GRP1_LEVEL_I(lvl1),
        .GRP0_DIGITAL_I(din0), .GRP1_DIGITAL_I(din1), .GRP0_DIGITAL_O(dout0),
        .GRP1_DIGITAL_O(dout1), .IRQ_O(irq));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic give_up();
        err_count++;
        $display("MISMATCH at %0t: wait ran out", $time);
        close_out();
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // poll a register bit until it reaches a level, counting the polls
    task automatic poll(input logic [3:0] a, input int b, input logic lvl, output int polls);
        polls = 0;
        rd_reg(a, rv);
        while (rv[b] !== lvl)
        begin
            polls++;
            if (polls > 200)
                give_up();
            rd_reg(a, rv);
        end
    endtask

    function automatic logic [15:0] ctl(input int ch, input int mode, input logic st, input logic wfr,
        input logic grp, input logic sus);
        logic [15:0] v;
        v = 16'h0000;
        v[3:0] = ch[3:0];
        v[5:4] = mode[1:0];
        v[acs_pkg::CTRL_START] = st;
        v[acs_pkg::CTRL_WAIT_READ] = wfr;
        v[acs_pkg::CTRL_GROUP] = grp;
        v[acs_pkg::CTRL_OVR_SUSPEND] = sus;
        return v;
    endfunction

    function automatic logic [15:0] res(input logic g, input int ch);
        return {ch[3:0], 2'b00, g, ch[3:0], bump};
    endfunction

    // bound on the whole run
    initial
    begin
        repeat (100000) @(posedge clk);
        give_up();
    end

    // main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_reg(acs_pkg::ADDR_CTRL, rv);
        chk(rv & 16'h8000, 16'h8000);
        poll(acs_pkg::ADDR_CTRL, acs_pkg::CTRL_BUSY, 1'b0, n);
        chk(16'(n >= 8 && n <= 11), 16'h0001);
        rd_reg(acs_pkg::ADDR_TIMING, rv);
        chk(rv, 16'h0404);
        rd_reg(acs_pkg::ADDR_SCAN_MASK, rv);
        chk(rv, 16'hffff);
        rd_reg(acs_pkg::ADDR_IRQ_MASK, rv);
        chk(rv, 16'h0000);
        wr_reg(4'h8, 16'h1234);
        rd_reg(4'h8, rv);
        chk(rv, 16'h0000);
        chk(dout0, din0);
        chk({8'h00, dout1}, {8'h00, din1});
        $display("test reset done");
        // single conversions on both groups with the done interrupt
        wr_reg(acs_pkg::ADDR_TIMING, 16'h0202);
        wr_reg(acs_pkg::ADDR_IRQ_MASK, 16'h0001);
        for (int g = 0; g < 2; g++)
        begin
            wr_reg(acs_pkg::ADDR_CTRL, ctl(g ? 3 : 5, 0, 1'b1, 1'b0, g[0], 1'b0));
            poll(acs_pkg::ADDR_CTRL, acs_pkg::CTRL_START, 1'b0, n);
            rd_reg(acs_pkg::ADDR_RESULT, rv);
            chk(rv, res(g[0], g ? 3 : 5));
            chk({15'h0000, irq}, 16'h0001);
            rd_reg(acs_pkg::ADDR_IRQ_STATUS, rv);
            chk(rv & 16'h0001, 16'h0001);
            chk({15'h0000, irq}, 16'h0000);
        end
        $display("test single done");
        // a longer timing setting must lengthen the conversion
        for (int i = 0; i < 2; i++)
        begin
            wr_reg(acs_pkg::ADDR_TIMING, i ? 16'h0808 : 16'h0000);
            wr_reg(acs_pkg::ADDR_CTRL, ctl(0, 0, 1'b1, 1'b0, 1'b0, 1'b0));
            poll(acs_pkg::ADDR_CTRL, acs_pkg::CTRL_START, 1'b0, p[i]);
        end
        chk(16'(p[1] >= p[0] + 6), 16'h0001);
        wr_reg(acs_pkg::ADDR_TIMING, 16'h0202);
        rd_reg(acs_pkg::ADDR_IRQ_STATUS, rv);
        // read the last result so that the unread flag is clear for the suspend scan
        rd_reg(acs_pkg::ADDR_RESULT, rv);
        chk(rv, res(1'b0, 0));
        $display("test timing done");
        // scan single with overrun suspend keeps every result
        wr_reg(acs_pkg::ADDR_CTRL, ctl(3, 2, 1'b1, 1'b0, 1'b0, 1'b1));
        for (int k = 3; k >= 0; k--)
        begin
            poll(acs_pkg::ADDR_IRQ_STATUS, acs_pkg::IRQ_DONE, 1'b1, n);
            rd_reg(acs_pkg::ADDR_RESULT, rv);
            chk(rv, res(1'b0, k));
        end
        poll(acs_pkg::ADDR_CTRL, acs_pkg::CTRL_START, 1'b0, n);
        $display("test scan done");
        // scan continuous with wait for read holds each result
        wr_reg(acs_pkg::ADDR_CTRL, ctl(1, 3, 1'b1, 1'b1, 1'b0, 1'b0));
        for (int k = 0; k < 4; k++)
        begin
            repeat (40) @(posedge clk);
            rd_reg(acs_pkg::ADDR_RESULT, rv);
            chk(rv, res(1'b0, (k % 2) ? 0 : 1));
        end
        rd_reg(acs_pkg::ADDR_IRQ_STATUS, rv);
        chk(rv & 16'h0002, 16'h0000);
        $display("test scan continuous done");
        // continuous without protection flags an overrun
        wr_reg(acs_pkg::ADDR_IRQ_MASK, 16'h0002);
        wr_reg(acs_pkg::ADDR_CTRL, ctl(2, 1, 1'b1, 1'b0, 1'b0, 1'b0));
        rd_reg(acs_pkg::ADDR_IRQ_STATUS, rv);
        repeat (60) @(posedge clk);
        chk({15'h0000, irq}, 16'h0001);
        rd_reg(acs_pkg::ADDR_IRQ_STATUS, rv);
        chk(rv & 16'h0002, 16'h0002);
        bump <= 5'h11;
        repeat (30) @(posedge clk);
        rd_reg(acs_pkg::ADDR_RESULT, rv);
        chk(rv, res(1'b0, 2));
        // injected conversion of channel 6 in the middle of continuous mode
        wr_reg(acs_pkg::ADDR_INJ_CTRL, 16'h0026);
        repeat (40) @(posedge clk);
        rd_reg(acs_pkg::ADDR_INJ_RESULT, rv);
        chk(rv, {1'b0, 4'h6, 1'b0, 1'b0, 4'h6, bump});
        rd_reg(acs_pkg::ADDR_CTRL, rv);
        chk(rv & 16'h003f, 16'h0012);
        bump <= 5'h0a;
        repeat (30) @(posedge clk);
        rd_reg(acs_pkg::ADDR_RESULT, rv);
        chk(rv, res(1'b0, 2));
        $display("test continuous done");
        // overrun suspend raises no overrun flag; let the conversion in flight land first
        wr_reg(acs_pkg::ADDR_CTRL, ctl(4, 1, 1'b1, 1'b0, 1'b0, 1'b1));
        repeat (20) @(posedge clk);
        rd_reg(acs_pkg::ADDR_RESULT, rv);
        rd_reg(acs_pkg::ADDR_IRQ_STATUS, rv);
        repeat (60) @(posedge clk);
        rd_reg(acs_pkg::ADDR_IRQ_STATUS, rv);
        chk(rv & 16'h0002, 16'h0000);
        rd_reg(acs_pkg::ADDR_RESULT, rv);
        chk(rv, res(1'b0, 4));
        wr_reg(acs_pkg::ADDR_CTRL, 16'h0000);
        $display("test suspend done");
        // a second reset reruns the calibration
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_reg(acs_pkg::ADDR_CTRL, rv);
        chk(rv, 16'h8000);
        poll(acs_pkg::ADDR_CTRL, acs_pkg::CTRL_BUSY, 1'b0, n);
        chk(16'(n >= 8 && n <= 11), 16'h0001);
        $display("test second reset done");
        close_out();
    end
endmodule
`default_nettype wire
